// ---- logic/bcl_loader.sv ----
// What this block does
// - Strap low picks resonator, high internal oscillator
// - PLL straps preset output and feedback dividers; input divider fixed at 0
// - Tile clock follows the PLL ratio formula
// - Software may rewrite PLL values after boot
// - Pins float while reset pin held
// - Long internal reset, then pulls, then boot
// - Boot straps choose debug, link or flash
// - Security bit forces boot from OTP
// - Image: count, words, CRC or skip marker
// - Little-endian count and CRC; load at zero
// - Reflected CRC-32, all-ones seed, inverted result
// - Mode-0 flash master at 2.5 MHz
// - Read command then zero address, stream data
// - Flash bytes arrive least significant bit first
// - Flash boot pins are fixed
// - Link enabled 200 ns in, outputs low
// - Link: ack word, image, END, reply, free
// - Secure boot reads OTP from address zero
`timescale 1ns/1ps
`default_nettype none
`include "bcl_map.svh"

module bcl_loader
   import bcl_pkg::*;
#(
   parameter int unsigned IRST_CYCLES = `BCL_IRST_CYCLES
) (
   input  wire logic        clk,
   input  wire logic        rst,
   input  wire logic        oscillator_source_strap_n,
   input  wire logic        pll_strap_low,
   input  wire logic        pll_strap_high,
   input  wire logic [1:0]  boot_source_strap,
   input  wire logic [31:0] security_word,
   input  wire logic [16:0] osc_khz,
   output logic             osc_internal_sel,
   output logic      [2:0]  pll_output_divider,
   output logic      [11:0] pll_feedback,
   output logic      [5:0]  pll_input_divider,
   output logic      [31:0] tile_khz,
   input  wire logic        pll_cfg_wr,
   input  wire logic [2:0]  pll_cfg_od,
   input  wire logic [11:0] pll_cfg_f,
   input  wire logic [5:0]  pll_cfg_r,
   output logic             gpio_pull_en,
   output logic             boot_wait_debug,
   output logic             boot_halted,
   input  wire logic        spi_miso,
   output logic             spi_sclk,
   output logic             spi_sclk_oe,
   output logic             spi_ss_n,
   output logic             spi_ss_n_oe,
   output logic             spi_mosi,
   output logic             spi_mosi_oe,
   output logic             link_pulldown_en,
   output logic      [1:0]  link_out,
   output logic             link_out_oe,
   input  wire logic [1:0]  link_in,
   output logic             link_in_low,
   input  wire logic        link_rx_valid,
   input  wire logic [7:0]  link_rx_data,
   input  wire logic        link_rx_ctrl,
   output logic             link_tx_valid,
   output logic      [7:0]  link_tx_data,
   output logic             link_tx_ctrl,
   input  wire logic        link_tx_ready,
   output logic             chanend0_alloc,
   output logic      [31:0] ack_chanend,
   output logic             otp_rd,
   output logic      [10:0] otp_addr,
   input  wire logic [31:0] otp_rdata,
   output logic             ram_we,
   output logic      [13:0] ram_addr,
   output logic      [31:0] ram_wdata,
   output logic             exec_run,
   output logic      [13:0] exec_addr
);
   localparam logic [7:0] SPI_HALF = 8'(`BCL_SPI_HALF_CYC);
   localparam logic [7:0] LINK_DLY = 8'(`BCL_LINK_EN_CYC);
   localparam logic [19:0] IRST_LAST = 20'(IRST_CYCLES - 1);

   bcl_state_t  state_reg, state_next;
   bcl_src_t    src_reg;
   logic [4:0]  strap_s1_reg, strap_s2_reg;
   logic        miso_s1_reg, miso_s2_reg;
   logic [1:0]  lin_s1_reg, lin_s2_reg;
   logic [19:0] irst_cnt_reg;
   logic        osc_int_reg, pull_reg, link_en_reg, exec_reg;
   logic [2:0]  od_reg;
   logic [11:0] f_reg;
   logic [5:0]  r_reg;
   logic [31:0] tile_khz_reg;
   logic [7:0]  dly_reg;
   logic [1:0]  wcnt_reg;
   logic [23:0] wacc_reg;
   logic [31:0] left_reg, ack_reg;
   logic [13:0] wptr_reg, ram_addr_reg;
   logic        ram_we_reg;
   logic [31:0] ram_wdata_reg;
   logic        spi_oe_reg, spi_act_reg, sclk_reg;
   logic [7:0]  div_reg;
   logic [5:0]  bits_reg;
   logic [31:0] cmd_reg;
   logic [6:0]  rx_sh_reg;
   logic        otp_rd_reg, otp_pend_reg, otp_have_reg;
   logic [31:0] otp_word_reg;
   logic [1:0]  otp_bidx_reg;
   logic [10:0] otp_addr_reg;
   logic [31:0] crc_val;

   // Pin synchronisers; only the second stage is read
   wire [4:0] strap_pins = {boot_source_strap, pll_strap_high, pll_strap_low,
                            oscillator_source_strap_n};
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         strap_s1_reg <= 5'h00;
         strap_s2_reg <= 5'h00;
         miso_s1_reg  <= 1'b0;
         miso_s2_reg  <= 1'b0;
         lin_s1_reg   <= 2'h0;
         lin_s2_reg   <= 2'h0;
      end else begin
         strap_s1_reg <= strap_pins;
         strap_s2_reg <= strap_s1_reg;
         miso_s1_reg  <= spi_miso;
         miso_s2_reg  <= miso_s1_reg;
         lin_s1_reg   <= link_in;
         lin_s2_reg   <= lin_s1_reg;
      end
   end

   // Strap decode; sampled once, so later strap motion is harmless
   wire       secure    = security_word[`BCL_SEC_BOOT_BIT];
   wire [1:0] pll_pat   = strap_s2_reg[`BCL_STRAP_PLL_HI:`BCL_STRAP_PLL_LO];
   wire [1:0] boot_pat  = strap_s2_reg[`BCL_STRAP_BOOT_HI:`BCL_STRAP_BOOT_LO];
   wire [2:0] strap_od  = (pll_pat == 2'h0) ? `BCL_PLL00_OD :
                          (pll_pat == 2'h3) ? `BCL_PLL11_OD :
                          (pll_pat == 2'h2) ? `BCL_PLL10_OD : `BCL_PLL01_OD;
   wire [11:0] strap_f  = (pll_pat == 2'h0) ? `BCL_PLL00_F :
                          (pll_pat == 2'h3) ? `BCL_PLL11_F :
                          (pll_pat == 2'h2) ? `BCL_PLL10_F : `BCL_PLL01_F;
   wire       irst_end  = (state_reg == BCL_ST_IRESET) && (irst_cnt_reg == IRST_LAST);

   // Tile clock estimate from oscillator rate and PLL values
   wire [31:0] pll_mul  = 32'(osc_khz) * 32'({20'h00000, f_reg} + 32'h1);
   wire [31:0] pll_pre  = (pll_mul >> 1) / (32'(r_reg) + 32'h1);
   wire [31:0] tile_val = pll_pre / (32'(od_reg) + 32'h1);

   // Image byte stream, from whichever source is active
   wire loading  = (state_reg == BCL_ST_ACK) || (state_reg == BCL_ST_COUNT) ||
                   (state_reg == BCL_ST_PROG) || (state_reg == BCL_ST_CRC);
   wire half_tk  = spi_act_reg && (div_reg == SPI_HALF - 8'h01);
   wire sclk_rise = half_tk && !sclk_reg;
   wire sclk_fall = half_tk && sclk_reg;
   wire spi_cmd_done = (state_reg == BCL_ST_SPI_CMD) && sclk_rise && (bits_reg == 6'h1F);
   wire spi_stb  = (src_reg == BCL_SRC_SPI) && loading && sclk_rise &&
                   (bits_reg[2:0] == 3'h7);
   wire [7:0] spi_byte = {miso_s2_reg, rx_sh_reg};
   wire link_stb = (src_reg == BCL_SRC_LINK) && loading && link_rx_valid && !link_rx_ctrl;
   wire otp_stb  = (src_reg == BCL_SRC_OTP) && loading && otp_have_reg;
   wire [7:0] otp_byte = otp_word_reg[{otp_bidx_reg, 3'h0} +: 8];
   wire       byte_vld  = spi_stb || link_stb || otp_stb;
   wire [7:0] byte_dat  = spi_stb ? spi_byte : (link_stb ? link_rx_data : otp_byte);
   wire       word_done = byte_vld && (wcnt_reg == 2'h3);
   wire [31:0] full_word = {byte_dat, wacc_reg};
   wire crc_ok   = (full_word == `BCL_CRC_SKIP) || (full_word == crc_val);
   wire end_seen = link_rx_valid && link_rx_ctrl && (link_rx_data == `BCL_END_TOKEN);
   wire ack_null = (ack_reg == `BCL_NULL_CHANEND);

   // Checksum covers count and program bytes only
   bcl_crc32 u_crc (
      .clk     (clk),
      .rst     (rst),
      .init    (state_reg == BCL_ST_SELECT),
      .en      (byte_vld && ((state_reg == BCL_ST_COUNT) || (state_reg == BCL_ST_PROG))),
      .data    (byte_dat),
      .crc_out (crc_val)
   );

   // Boot sequencer
   always_comb begin
      state_next = state_reg;
      case (state_reg)
         BCL_ST_IRESET:   if (irst_end) state_next = BCL_ST_SELECT;
         BCL_ST_SELECT: begin
            if (secure) state_next = BCL_ST_COUNT;
            else if (boot_pat == 2'h3) state_next = BCL_ST_SPI_CMD;
            else if (boot_pat == 2'h2) state_next = BCL_ST_LINK_DLY;
            else state_next = BCL_ST_WAIT_DBG;
         end
         BCL_ST_LINK_DLY: if (dly_reg == 8'h00) state_next = BCL_ST_ACK;
         BCL_ST_SPI_CMD:  if (spi_cmd_done) state_next = BCL_ST_COUNT;
         BCL_ST_ACK:      if (word_done) state_next = BCL_ST_COUNT;
         BCL_ST_COUNT: begin
            if (word_done) state_next = (full_word == 32'h0) ? BCL_ST_CRC : BCL_ST_PROG;
         end
         BCL_ST_PROG:     if (word_done && left_reg == 32'h1) state_next = BCL_ST_CRC;
         BCL_ST_CRC: begin
            if (word_done) begin
               if (!crc_ok) state_next = BCL_ST_HALT;
               else if (src_reg == BCL_SRC_LINK) state_next = BCL_ST_ENDTOK;
               else state_next = BCL_ST_RUN;
            end
         end
         BCL_ST_ENDTOK:   if (end_seen) state_next = BCL_ST_SENDEND;
         BCL_ST_SENDEND:  if (ack_null || link_tx_ready) state_next = BCL_ST_RUN;
         BCL_ST_WAIT_DBG: state_next = BCL_ST_WAIT_DBG;
         BCL_ST_RUN:      state_next = BCL_ST_RUN;
         BCL_ST_HALT:     state_next = BCL_ST_HALT;
         default:         state_next = BCL_ST_HALT;
      endcase
   end

   // State and internal reset count
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         state_reg    <= BCL_ST_IRESET;
         irst_cnt_reg <= 20'h00000;
      end else begin
         state_reg    <= state_next;
         if (state_reg == BCL_ST_IRESET) irst_cnt_reg <= irst_cnt_reg + 20'h00001;
      end
   end

   // Clock source and pulls caught at end of reset; source choice in the select cycle after
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         osc_int_reg <= 1'b0;
         pull_reg    <= 1'b0;
         src_reg     <= BCL_SRC_NONE;
         spi_oe_reg  <= 1'b0;
      end else if (irst_end) begin
         osc_int_reg <= strap_s2_reg[`BCL_STRAP_OSC];
         pull_reg    <= 1'b1;
      end else if (state_reg == BCL_ST_SELECT) begin
         src_reg     <= (state_next == BCL_ST_COUNT)    ? BCL_SRC_OTP :
                        (state_next == BCL_ST_SPI_CMD)  ? BCL_SRC_SPI :
                        (state_next == BCL_ST_LINK_DLY) ? BCL_SRC_LINK : BCL_SRC_NONE;
         spi_oe_reg  <= (state_next == BCL_ST_SPI_CMD) && !secure;
      end
   end

   // PLL values: strap preset, then software may overwrite
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         od_reg <= `BCL_PLL00_OD;
         f_reg  <= `BCL_PLL00_F;
         r_reg  <= `BCL_PLL_R;
         tile_khz_reg <= 32'h0;
      end else begin
         tile_khz_reg <= tile_val;
         if (irst_end) begin
            od_reg <= strap_od;
            f_reg  <= strap_f;
            r_reg  <= `BCL_PLL_R;
         end else if (pll_cfg_wr && state_reg != BCL_ST_IRESET) begin
            od_reg <= pll_cfg_od;
            f_reg  <= pll_cfg_f;
            r_reg  <= pll_cfg_r;
         end
      end
   end

   // Link enable after the fixed delay; wires then held low
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         dly_reg     <= 8'h00;
         link_en_reg <= 1'b0;
      end else if (state_reg == BCL_ST_SELECT) begin
         dly_reg     <= LINK_DLY - 8'h01;
      end else if (state_reg == BCL_ST_LINK_DLY) begin
         dly_reg     <= dly_reg - 8'h01;
         if (dly_reg == 8'h00) link_en_reg <= 1'b1;
      end
   end

   // Word assembly, little end first
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         wcnt_reg <= 2'h0;
         wacc_reg <= 24'h000000;
         left_reg <= 32'h0;
         ack_reg  <= `BCL_NULL_CHANEND;
      end else if (byte_vld) begin
         wcnt_reg <= wcnt_reg + 2'h1;
         wacc_reg <= {byte_dat, wacc_reg[23:8]};
         if (word_done && state_reg == BCL_ST_ACK) ack_reg <= full_word;
         if (word_done && state_reg == BCL_ST_COUNT) left_reg <= full_word;
         if (word_done && state_reg == BCL_ST_PROG) left_reg <= left_reg - 32'h1;
      end
   end

   // Program words land from the bottom of RAM upward
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         wptr_reg      <= `BCL_RAM_BASE;
         ram_addr_reg  <= `BCL_RAM_BASE;
         ram_we_reg    <= 1'b0;
         ram_wdata_reg <= 32'h0;
         exec_reg      <= 1'b0;
      end else begin
         ram_we_reg <= word_done && (state_reg == BCL_ST_PROG);
         if (word_done && state_reg == BCL_ST_COUNT) wptr_reg <= `BCL_RAM_BASE;
         if (word_done && state_reg == BCL_ST_PROG) begin
            ram_addr_reg  <= wptr_reg;
            ram_wdata_reg <= full_word;
            wptr_reg      <= wptr_reg + 14'h0001;
         end
         if (state_next == BCL_ST_RUN) exec_reg <= 1'b1;
      end
   end

   // Flash master: mode 0, data out on falling, sampled on rising
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         spi_act_reg <= 1'b0;
         sclk_reg    <= 1'b0;
         div_reg     <= 8'h00;
         bits_reg    <= 6'h00;
         cmd_reg     <= 32'h0;
         rx_sh_reg   <= 7'h00;
      end else begin
         if (state_reg == BCL_ST_SELECT) begin
            spi_act_reg <= (state_next == BCL_ST_SPI_CMD);
            cmd_reg     <= {`BCL_SPI_READ_CMD, `BCL_SPI_START_ADDR};
         end else if (spi_act_reg && !loading && state_reg != BCL_ST_SPI_CMD) begin
            spi_act_reg <= 1'b0;
         end
         div_reg <= half_tk ? 8'h00 : (spi_act_reg ? div_reg + 8'h01 : 8'h00);
         if (half_tk) sclk_reg <= !sclk_reg;
         else if (spi_act_reg && !loading && state_reg != BCL_ST_SPI_CMD)
            sclk_reg <= 1'b0;
         if (sclk_fall) cmd_reg <= {cmd_reg[30:0], 1'b0};
         if (sclk_rise) begin
            bits_reg  <= spi_cmd_done ? 6'h00 : bits_reg + 6'h01;
            rx_sh_reg <= {miso_s2_reg, rx_sh_reg[6:1]};
         end
      end
   end

   // OTP words fetched one at a time, one cycle read latency
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         otp_rd_reg   <= 1'b0;
         otp_pend_reg <= 1'b0;
         otp_have_reg <= 1'b0;
         otp_word_reg <= 32'h0;
         otp_bidx_reg <= 2'h0;
         otp_addr_reg <= `BCL_OTP_BASE;
      end else begin
         otp_rd_reg   <= (src_reg == BCL_SRC_OTP) && loading && !otp_have_reg &&
                         !otp_rd_reg && !otp_pend_reg;
         otp_pend_reg <= otp_rd_reg;
         if (otp_pend_reg) begin
            otp_word_reg <= otp_rdata;
            otp_have_reg <= 1'b1;
         end else if (otp_stb) begin
            otp_bidx_reg <= otp_bidx_reg + 2'h1;
            if (otp_bidx_reg == 2'h3) begin
               otp_have_reg <= 1'b0;
               otp_addr_reg <= otp_addr_reg + 11'h001;
            end
         end
      end
   end

   // Pins stay undriven until the internal reset is over
   assign spi_sclk         = sclk_reg;
   assign spi_mosi         = cmd_reg[31];
   assign spi_ss_n         = !spi_act_reg;
   assign spi_sclk_oe      = spi_oe_reg;
   assign spi_ss_n_oe      = spi_oe_reg;
   assign spi_mosi_oe      = spi_oe_reg;
   assign link_out         = 2'h0;
   assign link_out_oe      = link_en_reg;
   assign link_pulldown_en = pull_reg && !link_en_reg;
   assign link_in_low      = (lin_s2_reg == 2'h0);
   assign link_tx_valid    = (state_reg == BCL_ST_SENDEND) && !ack_null;
   assign link_tx_data     = `BCL_END_TOKEN;
   assign link_tx_ctrl     = 1'b1;
   assign chanend0_alloc   = (src_reg == BCL_SRC_LINK) && (loading ||
                             state_reg == BCL_ST_ENDTOK || state_reg == BCL_ST_SENDEND);
   assign ack_chanend      = ack_reg;
   assign otp_rd           = otp_rd_reg;
   assign otp_addr         = otp_addr_reg;
   assign ram_we           = ram_we_reg;
   assign ram_addr         = ram_addr_reg;
   assign ram_wdata        = ram_wdata_reg;
   assign exec_run         = exec_reg;
   assign exec_addr        = `BCL_RAM_BASE;
   assign osc_internal_sel = osc_int_reg;
   assign pll_output_divider = od_reg;
   assign pll_feedback     = f_reg;
   assign pll_input_divider = r_reg;
   assign tile_khz         = tile_khz_reg;
   assign gpio_pull_en     = pull_reg;
   assign boot_wait_debug  = (state_reg == BCL_ST_WAIT_DBG);
   assign boot_halted      = (state_reg == BCL_ST_HALT);

   // Checks
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   sequence s_bad_crc;
      state_reg == BCL_ST_CRC && word_done && !crc_ok;
   endsequence
   sequence s_link_go;
      state_reg == BCL_ST_LINK_DLY && dly_reg == 8'h00;
   endsequence

   pins_float_a: assert property (state_reg == BCL_ST_IRESET |->
      !spi_sclk_oe && !link_out_oe && !gpio_pull_en)
      else $error("pins driven during internal reset");
   osc_pick_a: assert property (irst_end |=>
      osc_internal_sel == $past(strap_s2_reg[`BCL_STRAP_OSC]))
      else $error("oscillator choice wrong");
   pll_preset_a: assert property (irst_end && pll_pat == 2'h1 |=>
      pll_output_divider == 3'h2 && pll_feedback == 12'h017 && pll_input_divider == 6'h00)
      else $error("pll strap preset wrong");
   pll_write_a: assert property (pll_cfg_wr && state_reg != BCL_ST_IRESET && !irst_end |=>
      pll_feedback == $past(pll_cfg_f) && pll_output_divider == $past(pll_cfg_od))
      else $error("pll write lost");
   link_enable_a: assert property (s_link_go |=> link_out_oe && link_out == 2'h0
      && !link_pulldown_en) else $error("link enable wrong");
   crc_halt_a: assert property (s_bad_crc |=> boot_halted ##1 !exec_run)
      else $error("bad image not halted");
   secure_src_a: assert property (state_reg == BCL_ST_SELECT && secure |=>
      src_reg == BCL_SRC_OTP && !spi_sclk_oe) else $error("secure boot ignored");
   mosi_stable_a: assert property ($rose(spi_sclk) |-> $stable(spi_mosi))
      else $error("mosi moved on rising clock");
   first_word_a: assert property (state_reg == BCL_ST_PROG && word_done &&
      wptr_reg == `BCL_RAM_BASE |=> ram_we && ram_addr == 14'h0000)
      else $error("first word not at bottom");
endmodule
`default_nettype wire

// ---- logic/bcl_map.svh ----
`ifndef BCL_MAP_SVH
`define BCL_MAP_SVH

// Reset and timing figures, in their own units
`define BCL_IRST_CYCLES    750000
`define BCL_CLK_PERIOD_PS  4000
`define BCL_LINK_EN_NS     200
`define BCL_SPI_HALF_NS    200
`define BCL_LINK_EN_CYC    ((`BCL_LINK_EN_NS * 1000) / `BCL_CLK_PERIOD_PS)
`define BCL_SPI_HALF_CYC   ((`BCL_SPI_HALF_NS * 1000) / `BCL_CLK_PERIOD_PS)

// Image checksum and link constants
`define BCL_CRC_POLY       32'hEDB88320
`define BCL_CRC_INIT       32'hFFFFFFFF
`define BCL_CRC_SKIP       32'h0D15AB1E
`define BCL_NULL_CHANEND   32'h0000FF02
`define BCL_END_TOKEN      8'h01
`define BCL_SPI_READ_CMD   8'h03
`define BCL_SPI_START_ADDR 24'h000000
`define BCL_RAM_BASE       14'h0000
`define BCL_OTP_BASE       11'h000

// Security word bit forcing secure boot
`define BCL_SEC_BOOT_BIT   5

// Strap positions inside the synchronised strap vector
`define BCL_STRAP_OSC      0
`define BCL_STRAP_PLL_LO   1
`define BCL_STRAP_PLL_HI   2
`define BCL_STRAP_BOOT_LO  3
`define BCL_STRAP_BOOT_HI  4

// Default PLL settings per strap pattern {high,low}
`define BCL_PLL00_OD       3'h1
`define BCL_PLL00_F        12'h07A
`define BCL_PLL11_OD       3'h2
`define BCL_PLL11_F        12'h077
`define BCL_PLL10_OD       3'h2
`define BCL_PLL10_F        12'h031
`define BCL_PLL01_OD       3'h2
`define BCL_PLL01_F        12'h017
`define BCL_PLL_R          6'h00

`endif

// ---- logic/bcl_pkg.sv ----
package bcl_pkg;

   // Boot sequencer states
   typedef enum logic [3:0] {
      BCL_ST_IRESET   = 4'b0000,
      BCL_ST_SELECT   = 4'b0001,
      BCL_ST_WAIT_DBG = 4'b0010,
      BCL_ST_LINK_DLY = 4'b0011,
      BCL_ST_SPI_CMD  = 4'b0100,
      BCL_ST_ACK      = 4'b0101,
      BCL_ST_COUNT    = 4'b0110,
      BCL_ST_PROG     = 4'b0111,
      BCL_ST_CRC      = 4'b1000,
      BCL_ST_ENDTOK   = 4'b1001,
      BCL_ST_SENDEND  = 4'b1010,
      BCL_ST_RUN      = 4'b1011,
      BCL_ST_HALT     = 4'b1100
   } bcl_state_t;

   // Image byte source
   typedef enum logic [1:0] {
      BCL_SRC_NONE = 2'b00,
      BCL_SRC_SPI  = 2'b01,
      BCL_SRC_LINK = 2'b10,
      BCL_SRC_OTP  = 2'b11
   } bcl_src_t;

endpackage

// ---- logic/bcl_crc32.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "bcl_map.svh"

module bcl_crc32 (
   input  wire logic        clk,
   input  wire logic        rst,
   input  wire logic        init,
   input  wire logic        en,
   input  wire logic [7:0]  data,
   output logic      [31:0] crc_out
);
   logic [31:0] crc_reg;
   logic [31:0] step [0:8];

   // Reflected shifts, one stage per bit of the byte
   assign step[0] = crc_reg ^ {24'h000000, data};
   genvar gi;
   generate
      for (gi = 0; gi < 8; gi++) begin : g_bit
         assign step[gi+1] = step[gi][0] ? ((step[gi] >> 1) ^ `BCL_CRC_POLY)
                                         : (step[gi] >> 1);
      end
   endgenerate

   // Register seeded with all ones
   always_ff @(posedge clk or posedge rst) begin
      if (rst) crc_reg <= `BCL_CRC_INIT;
      else if (init) crc_reg <= `BCL_CRC_INIT;
      else if (en) crc_reg <= step[8];
   end

   // Remainder is inverted on the way out
   assign crc_out = ~crc_reg;
endmodule
`default_nettype wire

// ---- dv/bcl_flash_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module bcl_flash_model (
   input  wire logic spi_sclk,
   input  wire logic spi_ss_n,
   input  wire logic spi_mosi,
   output logic      spi_miso
);
   // One program word, skip marker in the checksum slot
   logic [95:0] image = {32'h0D15AB1E, 32'h12345678, 32'h00000001};
   int          n = 0;
   logic        d = 1'b0;
   logic [31:0] cmd = 32'h0;
   // First 32 rising edges carry the read command and address
   always @(posedge spi_sclk or posedge spi_ss_n) n <= spi_ss_n ? 0 : n + 1;
   always @(posedge spi_sclk) if (n < 32) cmd <= {cmd[30:0], spi_mosi};
   // Mode 0: shift on the falling edge, each byte LSB first
   always @(negedge spi_sclk) if (n >= 32 && n < 128) d <= image[n - 32];
   // No pull on this line, so a stale bit must not look valid
   assign spi_miso = spi_ss_n ? ~d : d;
endmodule
`default_nettype wire

// ---- dv/bcl_loader_tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none
module bcl_loader_tb_top;
   logic        clk, rst, oscillator_source_strap_n, pll_strap_low, pll_strap_high;
   logic        pll_cfg_wr, link_rx_valid, link_rx_ctrl, link_tx_ready, osc_internal_sel;
   logic        gpio_pull_en, boot_wait_debug, boot_halted, spi_sclk, spi_sclk_oe, spi_ss_n;
   logic        spi_ss_n_oe, spi_mosi, spi_mosi_oe, link_pulldown_en, link_out_oe, link_in_low;
   logic        link_tx_valid, link_tx_ctrl, chanend0_alloc, otp_rd, ram_we, exec_run;
   wire logic   spi_miso;
   logic [1:0]  boot_source_strap, link_in, link_out;
   logic [2:0]  pll_output_divider, pll_cfg_od;
   logic [5:0]  pll_input_divider, pll_cfg_r;
   logic [7:0]  link_rx_data, link_tx_data;
   logic [10:0] otp_addr;
   logic [11:0] pll_feedback, pll_cfg_f;
   logic [13:0] ram_addr, exec_addr;
   logic [16:0] osc_khz;
   logic [31:0] security_word, tile_khz, ack_chanend, otp_rdata, ram_wdata, ram_seen;
   int          n_mismatch, checks_done, i;

   bcl_loader #(.IRST_CYCLES(20)) dut (
      .clk, .rst, .oscillator_source_strap_n, .pll_strap_low, .pll_strap_high,
      .boot_source_strap, .security_word, .osc_khz, .osc_internal_sel, .pll_output_divider,
      .pll_feedback, .pll_input_divider, .tile_khz, .pll_cfg_wr, .pll_cfg_od, .pll_cfg_f,
      .pll_cfg_r, .gpio_pull_en, .boot_wait_debug, .boot_halted, .spi_miso, .spi_sclk,
      .spi_sclk_oe, .spi_ss_n, .spi_ss_n_oe, .spi_mosi, .spi_mosi_oe, .link_pulldown_en,
      .link_out, .link_out_oe, .link_in, .link_in_low, .link_rx_valid, .link_rx_data,
      .link_rx_ctrl, .link_tx_valid, .link_tx_data, .link_tx_ctrl, .link_tx_ready,
      .chanend0_alloc, .ack_chanend, .otp_rd, .otp_addr, .otp_rdata, .ram_we, .ram_addr,
      .ram_wdata, .exec_run, .exec_addr);
   bcl_flash_model flash (.spi_sclk, .spi_ss_n, .spi_mosi, .spi_miso);

   always #2 clk = ~clk;
   // Keep the word written at RAM base
   always @(posedge clk) if (ram_we && ram_addr == 14'h0000) ram_seen <= ram_wdata;
   // OTP image: count 1, one word, skip marker; valid the cycle after the strobe
   always @(posedge clk) if (otp_rd) otp_rdata <= (otp_addr == 11'h000) ? 32'h00000001 :
      (otp_addr == 11'h001) ? 32'hCAFE0001 : 32'h0D15AB1E;

   task automatic step; @(posedge clk); #1; endtask
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic give_verdict;
      $display("mismatches=%0d checks=%0d", n_mismatch, checks_done);
      if (n_mismatch == 0 && checks_done > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   // A wait that ran out ends the run
   task automatic bound(input logic ok);
      if (ok !== 1'b1) begin n_mismatch++; give_verdict; end
   endtask
   // Straps {boot[1:0], pll high, pll low, osc}
   task automatic boot(input logic [4:0] s);
      logic [14:0] e;
      {boot_source_strap, pll_strap_high, pll_strap_low, oscillator_source_strap_n} = s;
      rst = 1'b1;
      repeat (4) step;
      chk({spi_sclk_oe, spi_ss_n_oe, spi_mosi_oe, link_out_oe, gpio_pull_en}, 32'h0);
      rst = 1'b0;
      for (i = 0; i < 40 && !gpio_pull_en; i++) step;
      bound(gpio_pull_en);
      chk(i, 32'h14);
      chk({osc_internal_sel, link_pulldown_en}, {s[0], 1'b1});
      case (s[2:1])
         2'b00: e = {3'h1, 12'h07A};
         2'b11: e = {3'h2, 12'h077};
         2'b10: e = {3'h2, 12'h031};
         default: e = {3'h2, 12'h017};
      endcase
      chk({pll_output_divider, pll_feedback, pll_input_divider}, {e, 6'h00});
   endtask
   task automatic run(input logic halt);
      for (i = 0; i < 20000 && !exec_run && !boot_halted; i++) step;
      bound(exec_run | boot_halted);
      chk({boot_halted, exec_run, exec_addr}, {halt, !halt, 14'h0000});
   endtask
   task automatic spi_boot;
      boot(5'b11101);
      for (i = 0; i < 10 && spi_ss_n; i++) step;
      chk({spi_ss_n, spi_sclk, spi_sclk_oe, spi_ss_n_oe, spi_mosi_oe}, 32'h7);
      run(1'b0);
      chk(ram_seen, 32'h12345678);
      chk(flash.cmd, 32'h03000000);
      // Software rewrite of the PLL after boot
      {pll_cfg_od, pll_cfg_f, pll_cfg_r, pll_cfg_wr} = {3'h3, 12'h063, 6'h01, 1'b1};
      step;
      pll_cfg_wr = 1'b0;
      chk({spi_ss_n, spi_sclk}, 32'h2);
      step;
      chk({pll_output_divider, pll_feedback, pll_input_divider}, {3'h3, 12'h063, 6'h01});
      step;
      chk(tile_khz, 32'h0001E848);
   endtask
   task automatic link_boot(input logic [31:0] ack, input logic [31:0] crc, input logic halt);
      logic [95:0] w;
      w = {crc, 32'h0, ack};
      boot(5'b10010);
      for (i = 0; i < 100 && !link_out_oe; i++) step;
      bound(link_out_oe);
      chk({link_out, link_pulldown_en, chanend0_alloc, link_in_low}, 32'h3);
      chk(i, 32'h33);
      for (i = 0; i < 13; i++) begin
         {link_rx_data, link_rx_ctrl, link_rx_valid} = i < 12 ? {w[i*8 +: 8], 2'b01} : 10'h007;
         step;
      end
      link_rx_valid = 1'b0;
      chk({link_tx_valid, link_tx_ctrl, link_tx_data}, {!halt && ack != 32'h0000FF02, 9'h101});
      link_tx_ready = 1'b1;
      step;
      link_tx_ready = 1'b0;
      run(halt);
      chk(ack_chanend, ack);
      chk(chanend0_alloc, 32'h0);
   endtask
   task automatic debug_boot;
      boot(5'b01110);
      link_in = 2'h2;
      repeat (2) step;
      chk({boot_wait_debug, spi_sclk_oe, link_out_oe, link_in_low}, 32'h8);
      link_in = 2'h0;
   endtask
   task automatic otp_boot;
      security_word = 32'h00000020;
      boot(5'b11001);
      run(1'b0);
      chk(ram_seen, 32'hCAFE0001);
      chk({spi_sclk_oe, otp_addr}, 32'h3);
   endtask

   initial begin
      {clk, rst, pll_cfg_wr, link_rx_valid, link_rx_ctrl, link_rx_data} = {5'h08, 8'h00};
      {pll_cfg_od, pll_cfg_f, pll_cfg_r, link_in, link_tx_ready} = 24'h000000;
      {security_word, osc_khz} = {32'h0, 17'h04E20};
      n_mismatch = 0;
      checks_done = 0;
      spi_boot;
      link_boot(32'h0000FF02, 32'h0D15AB1E, 1'b0);
      link_boot(32'h00000102, 32'h2144DF1C, 1'b0);
      link_boot(32'h0000FF02, 32'h00000000, 1'b1);
      debug_boot;
      otp_boot;
      give_verdict;
   end
endmodule
`default_nettype wire
